// [bench/fp_status_exception_unit_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module fp_status_exception_unit_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, fp, tp, rp;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, lo;
    int fail_count, comparisons, nf, nt, nr;
    logic [31:0] cm [3] = '{32'h24, 32'h34, 32'h14};
    logic [63:0] ex [3] = '{'1, 64'h1, '1};
    logic [31:0] od [6] = '{'1, '1, 32'h2, 32'h0, 32'h1, 32'h0};
    fpx_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fault_pulse(fp), .trap_pulse(tp), .recover_pulse(rp));
    fpx_pipe_model pipe (.pclk(pclk), .presetn(presetn), .fault_pulse(fp), .trap_pulse(tp),
        .recover_pulse(rp), .n_fault(nf), .n_trap(nt), .n_rec(nr));
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    task automatic summarize;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input string s, input logic [63:0] g, input logic [63:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1;
        for (int n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
        if (pready !== 1'b1) begin
            fail_count++;
            summarize();
        end
        q = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : xfer
    initial begin
        presetn = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1;
        xfer(0, 8'h4c, 0);
        chk("unmapped", {q, 31'h0, err}, 64'h1);
        xfer(1, fpx_pkg::A_MAIN, 32'h55);
        xfer(1, fpx_pkg::A_CMD, {9'h0, 7'h20, 7'h0f, 9'h3});
        xfer(0, fpx_pkg::A_MAIN, 0);
        chk("setc", q, 32'h25);
        xfer(1, fpx_pkg::A_MAIN, 32'h1fa5);
        xfer(1, fpx_pkg::A_CMD, 32'h2);
        xfer(0, fpx_pkg::A_MAIN, 0);
        chk("clrf", q, 32'h25);
        xfer(1, fpx_pkg::A_ALT, 32'h1000);
        xfer(1, fpx_pkg::A_CMD, 32'h9);
        xfer(0, fpx_pkg::A_STAT, 0);
        chk("chk_miss", {q[1], nr[7:0]}, 64'h101);
        xfer(1, fpx_pkg::A_MAIN, 32'h1025);
        xfer(1, fpx_pkg::A_CMD, 32'h9);
        xfer(0, fpx_pkg::A_STAT, 0);
        chk("chk_seen", {q[1], nr[7:0]}, 64'h001);
        for (int k = 0; k < 6; k++) xfer(1, 8'(fpx_pkg::A_OPA_LO + 8'(4 * k)), od[k]);
        for (int i = 0; i < 3; i++) begin
            xfer(1, fpx_pkg::A_CMD, cm[i]);
            xfer(0, fpx_pkg::A_RES_LO, 0);
            lo = q;
            xfer(0, fpx_pkg::A_RES_HI, 0);
            chk("xma", {q, lo}, ex[i]);
        end
        xfer(1, fpx_pkg::A_FRDIS, 32'h1);
        xfer(1, fpx_pkg::A_FRN, 32'h2);
        xfer(1, fpx_pkg::A_CMD, 32'h24);
        xfer(0, fpx_pkg::A_CAUSE, 0);
        chk("frdis", {q, nf}, {32'h10, 32'h1});
        xfer(1, fpx_pkg::A_FRDIS, 32'h0);
        xfer(1, fpx_pkg::A_TRAPS, 32'h28);
        xfer(1, fpx_pkg::A_EXP, 32'h30123);
        xfer(1, fpx_pkg::A_EVT, 32'h2d0);
        xfer(1, fpx_pkg::A_CMD, 32'h5);
        xfer(0, fpx_pkg::A_CAUSE, 0);
        chk("trap", {q, nt}, {32'h6800, 32'h1});
        xfer(0, fpx_pkg::A_MAIN, 0);
        chk("trap_flags", q, 32'h1425);
        xfer(0, fpx_pkg::A_EXPO, 0);
        chk("ovf_expo", q, 32'h23);
        xfer(1, fpx_pkg::A_TRAPS, 32'h5);
        xfer(1, fpx_pkg::A_EVT, 32'h6);
        xfer(1, fpx_pkg::A_CMD, 32'h5);
        xfer(0, fpx_pkg::A_CAUSE, 0);
        chk("fault", {q, nf}, {32'h1, 32'h2});
        xfer(0, fpx_pkg::A_MAIN, 0);
        chk("fault_flags", q, 32'h1425);
        xfer(1, fpx_pkg::A_TRAPS, 32'h10);
        xfer(1, fpx_pkg::A_EVT, 32'h20);
        xfer(1, fpx_pkg::A_CMD, 32'h5);
        xfer(0, fpx_pkg::A_CAUSE, 0);
        chk("unf_trap", {q, nt}, {32'h1000, 32'h2});
        xfer(0, fpx_pkg::A_EXPO, 0);
        chk("unf_expo", q, 32'h10123);
        xfer(0, fpx_pkg::A_MAIN, 0);
        chk("unf_flags", q, 32'h1c25);
        xfer(1, fpx_pkg::A_TRAPS, 32'h0);
        xfer(1, fpx_pkg::A_EVT, 32'h410);
        xfer(1, fpx_pkg::A_CMD, 32'h5);
        xfer(0, fpx_pkg::A_STAT, 0);
        chk("ovf_off", {q, nt}, {32'h4, 32'h2});
        xfer(1, fpx_pkg::A_CMD, 32'h64);
        xfer(0, fpx_pkg::A_RES_LO, 0);
        lo = q;
        xfer(0, fpx_pkg::A_STAT, 0);
        chk("nat", {q, lo}, {32'hc, 32'h0});
        xfer(1, fpx_pkg::A_CMD, 32'ha);
        xfer(0, fpx_pkg::A_ALT, 0);
        chk("clrf_alt", q, 32'h0);
        summarize();
    end
endmodule : fp_status_exception_unit_tb
`default_nettype wire

// [bench/fpx_pipe_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fpx_pipe_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fault_pulse,
    input wire logic trap_pulse,
    input wire logic recover_pulse,
    output var int n_fault,
    output var int n_trap,
    output var int n_rec
);
    // pipeline counts each fault, trap and recover pulse of the unit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_fault <= 0;
            n_trap <= 0;
            n_rec <= 0;
        end else begin
            n_fault <= n_fault + int'(fault_pulse);
            n_trap <= n_trap + int'(trap_pulse);
            n_rec <= n_rec + int'(recover_pulse);
        end
    end
endmodule : fpx_pipe_model
`default_nettype wire

// [common/fpx_pkg.sv]
package fpx_pkg;
    // ----------------------------------------
    // register byte addresses
    // ----------------------------------------
    localparam logic [7:0] A_TRAPS = 8'h00;
    localparam logic [7:0] A_MAIN = 8'h04;
    localparam logic [7:0] A_ALT = 8'h08;
    localparam logic [7:0] A_FRDIS = 8'h0c;
    localparam logic [7:0] A_OPA_LO = 8'h10;
    localparam logic [7:0] A_OPA_HI = 8'h14;
    localparam logic [7:0] A_OPB_LO = 8'h18;
    localparam logic [7:0] A_OPB_HI = 8'h1c;
    localparam logic [7:0] A_OPC_LO = 8'h20;
    localparam logic [7:0] A_OPC_HI = 8'h24;
    localparam logic [7:0] A_EVT = 8'h28;
    localparam logic [7:0] A_EXP = 8'h2c;
    localparam logic [7:0] A_CMD = 8'h30;
    localparam logic [7:0] A_RES_LO = 8'h34;
    localparam logic [7:0] A_RES_HI = 8'h38;
    localparam logic [7:0] A_CAUSE = 8'h3c;
    localparam logic [7:0] A_STAT = 8'h40;
    localparam logic [7:0] A_EXPO = 8'h44;
    localparam logic [7:0] A_FRN = 8'h48;
    // ----------------------------------------
    // status field: controls low, flags above
    // ----------------------------------------
    localparam int CTL_W = 7;
    localparam int FL_W = 6;
    localparam int FL_LSB = 7;
    localparam int SF_W = 13;
    localparam int FL_V = 0;
    localparam int FL_D = 1;
    localparam int FL_Z = 2;
    localparam int FL_O = 3;
    localparam int FL_U = 4;
    localparam int FL_I = 5;
    // ----------------------------------------
    // command word
    // ----------------------------------------
    localparam int C_OP = 0;
    localparam int C_SEL = 3;
    localparam int C_HIGH = 4;
    localparam int C_UNS = 5;
    localparam int C_NAT = 6;
    localparam int C_AND = 9;
    localparam int C_OR = 16;
    localparam logic [2:0] OP_CHKF = 3'h1;
    localparam logic [2:0] OP_CLRF = 3'h2;
    localparam logic [2:0] OP_SETC = 3'h3;
    localparam logic [2:0] OP_XMA = 3'h4;
    localparam logic [2:0] OP_ARITH = 3'h5;
    // ----------------------------------------
    // arithmetic event word
    // ----------------------------------------
    localparam int EV_W = 13;
    localparam int EV_SWAF = 0;
    localparam int EV_INV = 1;
    localparam int EV_ZDIV = 2;
    localparam int EV_DENO = 3;
    localparam int EV_OVF = 4;
    localparam int EV_TINY = 5;
    localparam int EV_INEX = 6;
    localparam int EV_INCR = 7;
    localparam int EV_SWAT = 8;
    localparam int EV_PAR = 9;
    localparam int EV_LARGER = 10;
    localparam int EV_SWAK = 11;
    localparam logic [1:0] SWAK_O = 2'h0;
    localparam logic [1:0] SWAK_U = 2'h1;
    // ----------------------------------------
    // interruption cause code
    // ----------------------------------------
    localparam int CAUSE_W = 16;
    localparam int CS_F_V = 0;
    localparam int CS_F_D = 1;
    localparam int CS_F_Z = 2;
    localparam int CS_F_SWA = 3;
    localparam int CS_DFR = 4;
    localparam int CS_T_O = 11;
    localparam int CS_T_U = 12;
    localparam int CS_T_I = 13;
    localparam int CS_RUP = 14;
    // ----------------------------------------
    // exponent, result kind, registers
    // ----------------------------------------
    localparam int EXP_W = 18;
    localparam int EXP_N = 17;
    localparam int EXP_P = 8;
    localparam logic [1:0] RK_NORM = 2'h0;
    localparam logic [1:0] RK_INF = 2'h1;
    localparam logic [1:0] RK_MAX = 2'h2;
    localparam logic [1:0] RK_NAT = 2'h3;
    localparam int FRN_W = 7;
    localparam int FR_CNT = 4;
    localparam logic [6:0] FR_LO_FIRST = 7'h02;
    localparam logic [6:0] FR_LO_LAST = 7'h1f;
    localparam logic [6:0] FR_HI_FIRST = 7'h20;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } fpx_state_t;
endpackage : fpx_pkg

// [rtl/fpx_frcheck.sv]
`timescale 1ns/1ps
`default_nettype none
module fpx_frcheck (
    input wire logic low_fr_disable,
    input wire logic high_fr_disable,
    input wire logic [27:0] fr_nums,
    output logic fault
);
    // ----------------------------------------
    // disabled register test, one per operand
    // ----------------------------------------
    function automatic logic fpx_fr_off(input logic [6:0] n, input logic lo, input logic hi);
        fpx_fr_off = (lo && n >= fpx_pkg::FR_LO_FIRST && n <= fpx_pkg::FR_LO_LAST)
            || (hi && n >= fpx_pkg::FR_HI_FIRST);
    endfunction : fpx_fr_off

    logic [fpx_pkg::FR_CNT-1:0] hit;
    genvar i;
    generate
        for (i = 0; i < fpx_pkg::FR_CNT; i++) begin : g_fr
            assign hit[i] = fpx_fr_off(fr_nums[i*fpx_pkg::FRN_W +: fpx_pkg::FRN_W],
                low_fr_disable, high_fr_disable);
        end
    endgenerate
    assign fault = |hit;
endmodule : fpx_frcheck
`default_nettype wire

// [rtl/fpx_muladd.sv]
`timescale 1ns/1ps
`default_nettype none
module fpx_muladd (
    input wire logic [63:0] sig_a,
    input wire logic [63:0] sig_b,
    input wire logic [63:0] sig_c,
    input wire logic uns,
    input wire logic high,
    output logic [63:0] result
);
    // ----------------------------------------
    // 65-bit extension covers both signednesses
    // ----------------------------------------
    logic signed [64:0] ax;
    logic signed [64:0] bx;
    logic signed [129:0] prod;
    logic [127:0] sum;
    assign ax = $signed({~uns & sig_a[63], sig_a});
    assign bx = $signed({~uns & sig_b[63], sig_b});
    assign prod = 130'(ax) * 130'(bx);
    assign sum = prod[127:0] + {64'h0, sig_c};
    assign result = high ? sum[127:64] : sum[63:0];
endmodule : fpx_muladd
`default_nettype wire

// [rtl/fpx_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module fpx_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic fault_pulse,
    output logic trap_pulse,
    output logic recover_pulse
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    fpx_pkg::fpx_state_t st_q;
    logic [5:0] trap_en_q;
    logic [12:0] main_sf_q, main_sf_d;
    logic [12:0] alt_sf_q, alt_sf_d;
    logic [1:0] frdis_q;
    logic [63:0] opa_q, opb_q, opc_q, res_q;
    logic [12:0] evt_q;
    logic [17:0] exp_q, expo_q;
    logic [31:0] cmd_q;
    logic [27:0] frn_q;
    logic [15:0] cause_q;
    logic [1:0] rkind_q;
    logic recov_q;
    logic [31:0] rdata;
    logic acc, wr_en, exec, dfr, natm, sel;
    logic [2:0] op;
    logic [63:0] mul_res;

    assign acc = psel && penable && !pready;
    assign wr_en = psel && penable && pready && pwrite;
    assign exec = st_q == fpx_pkg::ST_EXEC;
    assign op = cmd_q[fpx_pkg::C_OP +: 3];
    assign sel = cmd_q[fpx_pkg::C_SEL];
    assign natm = |cmd_q[fpx_pkg::C_NAT +: 3];

    fpx_frcheck u_frcheck (
        .low_fr_disable(frdis_q[0]),
        .high_fr_disable(frdis_q[1]),
        .fr_nums(frn_q),
        .fault(dfr)
    );

    fpx_muladd u_muladd (
        .sig_a(opa_q),
        .sig_b(opb_q),
        .sig_c(opc_q),
        .uns(cmd_q[fpx_pkg::C_UNS]),
        .high(cmd_q[fpx_pkg::C_HIGH]),
        .result(mul_res)
    );

    // ----------------------------------------
    // apb slave, one wait state
    // ----------------------------------------
    always_comb begin
        rdata = 32'h0;
        case (paddr)
            fpx_pkg::A_TRAPS: rdata = {26'h0, trap_en_q};
            fpx_pkg::A_MAIN: rdata = {19'h0, main_sf_q};
            fpx_pkg::A_ALT: rdata = {19'h0, alt_sf_q};
            fpx_pkg::A_FRDIS: rdata = {30'h0, frdis_q};
            fpx_pkg::A_OPA_LO: rdata = opa_q[31:0];
            fpx_pkg::A_OPA_HI: rdata = opa_q[63:32];
            fpx_pkg::A_OPB_LO: rdata = opb_q[31:0];
            fpx_pkg::A_OPB_HI: rdata = opb_q[63:32];
            fpx_pkg::A_OPC_LO: rdata = opc_q[31:0];
            fpx_pkg::A_OPC_HI: rdata = opc_q[63:32];
            fpx_pkg::A_EVT: rdata = {19'h0, evt_q};
            fpx_pkg::A_EXP: rdata = {14'h0, exp_q};
            fpx_pkg::A_CMD: rdata = cmd_q;
            fpx_pkg::A_RES_LO: rdata = res_q[31:0];
            fpx_pkg::A_RES_HI: rdata = res_q[63:32];
            fpx_pkg::A_CAUSE: rdata = {16'h0, cause_q};
            fpx_pkg::A_STAT: rdata = {28'h0, rkind_q, recov_q, exec};
            fpx_pkg::A_EXPO: rdata = {14'h0, expo_q};
            fpx_pkg::A_FRN: rdata = {4'h0, frn_q};
            default: rdata = 32'h0;
        endcase
    end

    function automatic logic fpx_mapped(input logic [7:0] a);
        fpx_mapped = a[1:0] == 2'h0 && a <= fpx_pkg::A_FRN;
    endfunction : fpx_mapped

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= acc;
            pslverr <= acc && !fpx_mapped(paddr);
            prdata <= (acc && !pwrite) ? rdata : 32'h0;
        end
    end

    // ----------------------------------------
    // operand and control registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_en_q <= 6'h0;
            frdis_q <= 2'h0;
            opa_q <= 64'h0;
            opb_q <= 64'h0;
            opc_q <= 64'h0;
            evt_q <= 13'h0;
            exp_q <= 18'h0;
            frn_q <= 28'h0;
        end else if (wr_en) begin
            case (paddr)
                fpx_pkg::A_TRAPS: trap_en_q <= pwdata[5:0];
                fpx_pkg::A_FRDIS: frdis_q <= pwdata[1:0];
                fpx_pkg::A_OPA_LO: opa_q[31:0] <= pwdata;
                fpx_pkg::A_OPA_HI: opa_q[63:32] <= pwdata;
                fpx_pkg::A_OPB_LO: opb_q[31:0] <= pwdata;
                fpx_pkg::A_OPB_HI: opb_q[63:32] <= pwdata;
                fpx_pkg::A_OPC_LO: opc_q[31:0] <= pwdata;
                fpx_pkg::A_OPC_HI: opc_q[63:32] <= pwdata;
                fpx_pkg::A_EVT: evt_q <= pwdata[12:0];
                fpx_pkg::A_EXP: exp_q <= pwdata[17:0];
                fpx_pkg::A_FRN: frn_q <= pwdata[27:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // command sequencing
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= fpx_pkg::ST_IDLE;
            cmd_q <= 32'h0;
        end else begin
            case (st_q)
                fpx_pkg::ST_IDLE: begin
                    if (wr_en && paddr == fpx_pkg::A_CMD) begin
                        cmd_q <= pwdata;
                        st_q <= fpx_pkg::ST_EXEC;
                    end
                end
                fpx_pkg::ST_EXEC: st_q <= fpx_pkg::ST_IDLE;
                default: st_q <= fpx_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // exception evaluation
    // ----------------------------------------
    logic f_inv, f_z, f_d, f_swa, fault_any;
    logic ovf, unf, inx, t_o, t_u, t_i, t_swa, trap_any, rup;
    logic [5:0] fl_set;
    logic [15:0] cause_new;
    logic [17:0] expo_new;
    logic [1:0] rkind_new;
    logic chk_hit;
    logic [5:0] alt_fl, main_fl;

    assign main_fl = main_sf_q[fpx_pkg::FL_LSB +: fpx_pkg::FL_W];
    assign alt_fl = sel ? alt_sf_q[fpx_pkg::FL_LSB +: fpx_pkg::FL_W] : main_fl;
    assign chk_hit = |(alt_fl & trap_en_q) || |(alt_fl & ~main_fl);

    always_comb begin
        f_inv = evt_q[fpx_pkg::EV_INV] && trap_en_q[fpx_pkg::FL_V];
        f_z = evt_q[fpx_pkg::EV_ZDIV] && trap_en_q[fpx_pkg::FL_Z];
        f_d = evt_q[fpx_pkg::EV_DENO] && trap_en_q[fpx_pkg::FL_D];
        f_swa = evt_q[fpx_pkg::EV_SWAF] && !natm;
        fault_any = f_inv || f_z || f_d || f_swa;
        ovf = evt_q[fpx_pkg::EV_OVF];
        unf = trap_en_q[fpx_pkg::FL_U] ? evt_q[fpx_pkg::EV_TINY]
            : evt_q[fpx_pkg::EV_TINY] && evt_q[fpx_pkg::EV_INEX];
        inx = evt_q[fpx_pkg::EV_INEX] || (ovf && !trap_en_q[fpx_pkg::FL_O]);
        t_o = ovf && trap_en_q[fpx_pkg::FL_O];
        t_u = unf && trap_en_q[fpx_pkg::FL_U] && !t_o;
        t_i = inx && trap_en_q[fpx_pkg::FL_I];
        t_swa = evt_q[fpx_pkg::EV_SWAT];
        trap_any = t_o || t_u || t_i || t_swa;
        rup = evt_q[fpx_pkg::EV_INCR]
            || (ovf && !trap_en_q[fpx_pkg::FL_O] && evt_q[fpx_pkg::EV_LARGER]);
        fl_set = 6'h0;
        fl_set[fpx_pkg::FL_V] = evt_q[fpx_pkg::EV_INV];
        fl_set[fpx_pkg::FL_Z] = evt_q[fpx_pkg::EV_ZDIV] && !evt_q[fpx_pkg::EV_INV];
        fl_set[fpx_pkg::FL_D] = evt_q[fpx_pkg::EV_DENO] && !evt_q[fpx_pkg::EV_INV]
            && !evt_q[fpx_pkg::EV_ZDIV];
        fl_set[fpx_pkg::FL_O] = ovf;
        fl_set[fpx_pkg::FL_U] = unf;
        fl_set[fpx_pkg::FL_I] = inx;
        cause_new = 16'h0;
        if (fault_any) begin
            if (f_inv) cause_new[fpx_pkg::CS_F_V] = 1'b1;
            else if (f_z) cause_new[fpx_pkg::CS_F_Z] = 1'b1;
            else if (f_d) cause_new[fpx_pkg::CS_F_D] = 1'b1;
            else cause_new[fpx_pkg::CS_F_SWA] = 1'b1;
        end else if (trap_any) begin
            cause_new[fpx_pkg::CS_T_O] = t_o || (t_swa && evt_q[fpx_pkg::EV_SWAK +: 2] == fpx_pkg::SWAK_O);
            cause_new[fpx_pkg::CS_T_U] = t_u || (t_swa && evt_q[fpx_pkg::EV_SWAK +: 2] == fpx_pkg::SWAK_U);
            cause_new[fpx_pkg::CS_T_I] = t_i || (t_swa && evt_q[fpx_pkg::EV_SWAK +: 2] > fpx_pkg::SWAK_U);
            cause_new[fpx_pkg::CS_RUP] = rup;
        end
        expo_new = exp_q;
        if (t_o || t_u || t_swa) begin
            if (evt_q[fpx_pkg::EV_PAR]) expo_new = {10'h0, exp_q[fpx_pkg::EXP_P-1:0]};
            else expo_new = {1'b0, exp_q[fpx_pkg::EXP_N-1:0]};
        end
        rkind_new = fpx_pkg::RK_NORM;
        if (ovf && !trap_en_q[fpx_pkg::FL_O]) begin
            rkind_new = evt_q[fpx_pkg::EV_LARGER] ? fpx_pkg::RK_INF : fpx_pkg::RK_MAX;
        end
    end

    // ----------------------------------------
    // status fields, set beats software write
    // ----------------------------------------
    logic [12:0] tgt_d;
    always_comb begin
        main_sf_d = main_sf_q;
        alt_sf_d = alt_sf_q;
        if (wr_en && paddr == fpx_pkg::A_MAIN) main_sf_d = pwdata[12:0];
        if (wr_en && paddr == fpx_pkg::A_ALT) alt_sf_d = pwdata[12:0];
        tgt_d = sel ? alt_sf_d : main_sf_d;
        if (exec) begin
            case (op)
                fpx_pkg::OP_CLRF: tgt_d[fpx_pkg::FL_LSB +: fpx_pkg::FL_W] = 6'h0;
                fpx_pkg::OP_SETC: tgt_d[fpx_pkg::CTL_W-1:0] = (main_sf_q[fpx_pkg::CTL_W-1:0]
                    & cmd_q[fpx_pkg::C_AND +: fpx_pkg::CTL_W]) | cmd_q[fpx_pkg::C_OR +: fpx_pkg::CTL_W];
                fpx_pkg::OP_ARITH: begin
                    if (!dfr && !natm && !fault_any) begin
                        tgt_d[fpx_pkg::FL_LSB +: fpx_pkg::FL_W] = tgt_d[fpx_pkg::FL_LSB +: fpx_pkg::FL_W]
                            | fl_set;
                    end
                end
                default: ;
            endcase
        end
        if (sel) alt_sf_d = tgt_d;
        else main_sf_d = tgt_d;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_sf_q <= 13'h0;
            alt_sf_q <= 13'h0;
        end else begin
            main_sf_q <= main_sf_d;
            alt_sf_q <= alt_sf_d;
        end
    end

    // ----------------------------------------
    // results and reporting
    // ----------------------------------------
    logic fp_op;
    assign fp_op = op == fpx_pkg::OP_XMA || op == fpx_pkg::OP_ARITH;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_q <= 64'h0;
            cause_q <= 16'h0;
            expo_q <= 18'h0;
            rkind_q <= fpx_pkg::RK_NORM;
            recov_q <= 1'b0;
            fault_pulse <= 1'b0;
            trap_pulse <= 1'b0;
            recover_pulse <= 1'b0;
        end else begin
            fault_pulse <= 1'b0;
            trap_pulse <= 1'b0;
            recover_pulse <= 1'b0;
            if (exec && op == fpx_pkg::OP_CHKF) begin
                recov_q <= chk_hit;
                recover_pulse <= chk_hit;
            end
            if (exec && fp_op) begin
                if (dfr) begin
                    cause_q <= 16'h0010;
                    fault_pulse <= 1'b1;
                end else if (natm) begin
                    res_q <= 64'h0;
                    rkind_q <= fpx_pkg::RK_NAT;
                    cause_q <= 16'h0;
                end else if (op == fpx_pkg::OP_XMA) begin
                    res_q <= mul_res;
                    rkind_q <= fpx_pkg::RK_NORM;
                    cause_q <= 16'h0;
                end else begin
                    cause_q <= cause_new;
                    fault_pulse <= fault_any;
                    trap_pulse <= !fault_any && trap_any;
                    if (!fault_any) begin
                        expo_q <= expo_new;
                        rkind_q <= rkind_new;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [127:0] ref_u, ref_s, ref_full;
    logic [63:0] ref_sel;
    assign ref_u = {64'h0, opa_q} * {64'h0, opb_q};
    assign ref_s = 128'($signed(opa_q)) * 128'($signed(opb_q));
    assign ref_full = (cmd_q[fpx_pkg::C_UNS] ? ref_u : ref_s) + {64'h0, opc_q};
    assign ref_sel = cmd_q[fpx_pkg::C_HIGH] ? ref_full[127:64] : ref_full[63:0];

    AST_CHKF: assert property (exec && op == fpx_pkg::OP_CHKF |=> recover_pulse == $past(chk_hit)
        && $stable(main_sf_q)) else $error("check-flags outcome wrong");
    AST_SETC: assert property (exec && op == fpx_pkg::OP_SETC && !sel |=> main_sf_q[6:0] ==
        (($past(main_sf_q[6:0]) & $past(cmd_q[15:9])) | $past(cmd_q[22:16])))
        else $error("set-controls value wrong");
    AST_CLRF: assert property (exec && op == fpx_pkg::OP_CLRF && sel |=> alt_sf_q[12:7] == 6'h0)
        else $error("clear-flags left a flag");
    AST_XMA: assert property (exec && op == fpx_pkg::OP_XMA && !dfr && !natm |=> res_q == $past(ref_sel))
        else $error("multiply-add result wrong");
    AST_DFR: assert property (exec && fp_op && dfr |=> cause_q == 16'h0010 && fault_pulse
        && !trap_pulse && $stable(main_sf_q) && $stable(alt_sf_q)) else $error("disabled fault");
    AST_FAULT_FLAGS: assert property (fault_pulse |-> $stable(main_sf_q) && $stable(alt_sf_q))
        else $error("fault changed flags");
    AST_ONE_FAULT: assert property (fault_pulse |-> $onehot(cause_q[4:0]))
        else $error("more than one fault flagged");
    AST_UNF_TRAP: assert property (exec && op == fpx_pkg::OP_ARITH && !dfr && !natm && !fault_any
        && trap_en_q[4] && evt_q[5] && !t_o |=> trap_pulse && cause_q[12])
        else $error("enabled underflow not trapped");
    AST_WRAP: assert property (exec && op == fpx_pkg::OP_ARITH && !dfr && !natm && !fault_any && t_o
        && evt_q[9] |=> expo_q == {10'h0, $past(exp_q[7:0])} ##1 trap_pulse == 1'b0)
        else $error("parallel exponent wrap wrong");
    AST_APB: assert property (psel && !penable ##1 psel && penable |-> ##1 pready ##1 !pready)
        else $error("apb answer not one wait state");
    COV_RECOVER: cover property (recover_pulse);
    COV_TRAP_OI: cover property (trap_pulse && cause_q[11] && cause_q[13]);
    COV_DFR: cover property (fault_pulse && cause_q[4]);
endmodule : fpx_unit
`default_nettype wire
